// ==== src/mwf_fetch.sv ====
// Fetch and decode of one- to three-word instructions from byte-addressed program memory.
// Assumes memory answers within the cycle of a request, on the same clock, and an
// asynchronous skip request from the core's condition logic.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Program memory is addressed in bytes and every instruction word starts on an even byte.
// - The program counter steps by two and its bit zero always reads zero.
// - Absolute jump and call targets are word addresses loaded into counter bits 20 to 1.
// - Relative branch offsets count words, so they are doubled before being added.
// - Jump, call, file move and pointer load take two words; long and stack moves take three.
// - Extension words carry 1111 in the top nibble and twelve bits of literal below.
// - An extension word fetched right after its first word supplies the instruction literal.
// - A 1111-prefixed word executed on its own acts as a no-operation.
module mwf_fetch (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [15:0] i_mem_word,
	input wire logic i_mem_valid,
	input wire logic i_skip,
	output logic [mwf_pkg::PC_W-1:0] o_mem_addr,
	output logic o_mem_req,
	output mwf_pkg::mwf_issue_t o_issue
);
	import mwf_pkg::*;

	// ****************************************
	// Reset release and input sync
	// ****************************************
	logic [1:0] rst_sync_r;
	logic rst_n;
	logic skip_s;
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	mwf_sync u_skip_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(rst_n),
		.i_d(i_skip),
		.o_q(skip_s)
	);

	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic mwf_kind_t classify(input logic [15:0] w);
		mwf_kind_t k;
		k = K_SINGLE;
		if (w[15:12] == EXT_PREFIX) begin
			k = K_NOP_EXT;
		end else if (w[15:8] == OP_JUMP) begin
			k = K_JUMP;
		end else if (w[15:8] == OP_CALL_LO || w[15:8] == OP_CALL_HI) begin
			k = K_CALL;
		end else if (w[15:12] == OP_FILE_MOVE) begin
			k = K_FILE_MOVE;
		end else if (w[15:6] == OP_LOAD_PTR) begin
			k = K_LOAD_PTR;
		end else if (w[15:4] == OP_LONG_MOVE) begin
			k = K_LONG_MOVE;
		end else if (w[15:5] == OP_STACK_MOVE) begin
			k = K_STACK_MOVE;
		end else if (w[15:11] == OP_BRA || w[15:11] == OP_RCALL || w[15:11] == OP_BCOND) begin
			k = K_BRANCH;
		end
		return k;
	endfunction : classify

	function automatic logic [1:0] ext_count(input mwf_kind_t k);
		logic [1:0] n;
		n = EXT_NONE;
		if (k == K_LONG_MOVE || k == K_STACK_MOVE) begin
			n = EXT_TWO;
		end else if (k == K_JUMP || k == K_CALL || k == K_FILE_MOVE || k == K_LOAD_PTR) begin
			n = EXT_ONE;
		end
		return n;
	endfunction : ext_count

	// ****************************************
	// Sequencer
	// ****************************************
	mwf_state_t state_r;
	mwf_state_t state_nxt;
	logic [20:0] pc_r;
	logic [20:0] pc_nxt;
	logic [1:0] remain_r;
	logic [1:0] remain_nxt;
	mwf_issue_t hold_r;
	mwf_issue_t hold_nxt;
	mwf_issue_t issue_r;
	mwf_issue_t issue_nxt;
	logic req_r;
	logic req_nxt;
	logic [20:0] target_r;
	logic [20:0] target_nxt;
	logic [11:0] lit;
	mwf_kind_t kind;
	logic [20:0] rel;

	always_comb begin
		state_nxt = state_r;
		pc_nxt = pc_r;
		remain_nxt = remain_r;
		hold_nxt = hold_r;
		issue_nxt = issue_r;
		issue_nxt.valid = 1'b0;
		req_nxt = 1'b1;
		target_nxt = target_r;
		lit = i_mem_word[EXT_LIT_W-1:0];
		kind = classify(i_mem_word);
		// Offset is an eleven-bit word count, sign extended then shifted to bytes.
		rel = {{9{i_mem_word[10]}}, i_mem_word[10:0], 1'b0};
		case (state_r)
			ST_FIRST: begin
				if (i_mem_valid) begin
					pc_nxt = pc_r + 21'h00_0002;
					hold_nxt.valid = 1'b1;
					hold_nxt.kind = kind;
					hold_nxt.first = i_mem_word;
					hold_nxt.lit1 = 12'h000;
					hold_nxt.lit2 = 12'h000;
					hold_nxt.pc = pc_r;
					target_nxt = {13'h0000, i_mem_word[7:0]};
					if (skip_s && ext_count(kind) == EXT_NONE) begin
						// A skipped single word retires nothing; a stray extension word
						// arriving here in first-word state is classed as a NOP, a single word, and is dropped too.
						hold_nxt.valid = 1'b0;
					end else if (ext_count(kind) != EXT_NONE) begin
						remain_nxt = ext_count(kind);
						state_nxt = ST_EXT;
					end else begin
						issue_nxt = hold_nxt;
						issue_nxt.valid = 1'b1;
						if (kind == K_BRANCH) begin
							pc_nxt = pc_r + 21'h00_0002 + rel;
							state_nxt = ST_REDIRECT;
							req_nxt = 1'b0;
						end
					end
				end
			end
			ST_EXT: begin
				if (i_mem_valid) begin
					pc_nxt = pc_r + 21'h00_0002;
					if (i_mem_word[15:12] == EXT_PREFIX) begin
						// Only here is a 1111 word taken as an operand.
						if (remain_r == EXT_TWO && hold_nxt.lit1 == 12'h000 &&
								(hold_r.kind == K_LONG_MOVE || hold_r.kind == K_STACK_MOVE)) begin
							hold_nxt.lit1 = lit;
						end else if (remain_r == EXT_TWO || hold_r.kind == K_SINGLE) begin
							hold_nxt.lit1 = lit;
						end else if (hold_r.kind == K_LONG_MOVE || hold_r.kind == K_STACK_MOVE) begin
							hold_nxt.lit2 = lit;
						end else begin
							hold_nxt.lit1 = lit;
						end
						remain_nxt = remain_r - 2'h1;
						if (remain_r == EXT_ONE) begin
							state_nxt = ST_FIRST;
							issue_nxt = hold_nxt;
							issue_nxt.valid = 1'b1;
							if (hold_r.kind == K_JUMP || hold_r.kind == K_CALL) begin
								// Target word address fills bits 20:1; bit zero stays zero.
								pc_nxt = {lit, target_r[7:0], 1'b0};
								state_nxt = ST_REDIRECT;
								req_nxt = 1'b0;
							end
						end
					end else begin
						// Malformed sequence: abandon it and refetch the word as a first word.
						pc_nxt = pc_r;
						remain_nxt = EXT_NONE;
						state_nxt = ST_FIRST;
						req_nxt = 1'b0;
					end
				end
			end
			ST_REDIRECT: begin
				// One idle cycle drops the word already in flight from the old path.
				state_nxt = ST_FIRST;
			end
			default: begin
				state_nxt = ST_FIRST;
			end
		endcase
		pc_nxt[0] = 1'b0;
	end

	always_ff @(posedge i_sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_FIRST;
			pc_r <= PC_RST;
			remain_r <= EXT_NONE;
			hold_r <= '0;
			issue_r <= '0;
			req_r <= 1'b0;
			target_r <= PC_RST;
		end else begin
			state_r <= state_nxt;
			pc_r <= pc_nxt;
			remain_r <= remain_nxt;
			hold_r <= hold_nxt;
			issue_r <= issue_nxt;
			req_r <= req_nxt;
			target_r <= target_nxt;
		end
	end

	assign o_mem_addr = pc_r;
	assign o_mem_req = req_r;
	assign o_issue = issue_r;
endmodule : mwf_fetch
`default_nettype wire

// ==== src/mwf_pkg.sv ====
// Package of the multi-word instruction fetch block: widths, opcode prefixes, structs.
// Assumes a 21-bit byte-addressed program space and 16-bit instruction words.
package mwf_pkg;
	// ****************************************
	// Widths and reset values
	// ****************************************
	localparam int PC_W = 21;
	localparam logic [20:0] PC_RST = 21'h00_0000;
	localparam int PC_WORD_LSB = 1;
	localparam logic [3:0] EXT_PREFIX = 4'hF;
	localparam int EXT_LIT_W = 12;
	localparam logic [1:0] EXT_NONE = 2'h0;
	localparam logic [1:0] EXT_ONE = 2'h1;
	localparam logic [1:0] EXT_TWO = 2'h2;
	localparam int SYNC_STAGES = 3;

	// ****************************************
	// Opcode classes
	// ****************************************
	localparam logic [7:0] OP_JUMP = 8'hEF;
	localparam logic [7:0] OP_CALL_LO = 8'hEC;
	localparam logic [7:0] OP_CALL_HI = 8'hED;
	localparam logic [3:0] OP_FILE_MOVE = 4'hC;
	localparam logic [9:0] OP_LOAD_PTR = 10'h3B8;
	localparam logic [11:0] OP_LONG_MOVE = 12'h006;
	localparam logic [10:0] OP_STACK_MOVE = 11'h00B;
	localparam logic [4:0] OP_BRA = 5'h1A;
	localparam logic [4:0] OP_RCALL = 5'h1B;
	localparam logic [4:0] OP_BCOND = 5'h1C;

	typedef enum logic [2:0] {
		ST_FIRST = 3'b001,
		ST_EXT = 3'b010,
		ST_REDIRECT = 3'b100
	} mwf_state_t;

	typedef enum logic [3:0] {
		K_SINGLE = 4'h0,
		K_JUMP = 4'h1,
		K_CALL = 4'h2,
		K_FILE_MOVE = 4'h3,
		K_LOAD_PTR = 4'h4,
		K_LONG_MOVE = 4'h5,
		K_STACK_MOVE = 4'h6,
		K_BRANCH = 4'h7,
		K_NOP_EXT = 4'h8
	} mwf_kind_t;

	typedef struct packed {
		logic valid;
		mwf_kind_t kind;
		logic [15:0] first;
		logic [11:0] lit1;
		logic [11:0] lit2;
		logic [20:0] pc;
	} mwf_issue_t;
endpackage : mwf_pkg

// ==== src/mwf_sync.sv ====
// Three-stage input synchroniser with agreement of stages two and three.
// Assumes the input is asynchronous to i_sys_clk.
`timescale 1ns/1ns
`default_nettype none
module mwf_sync (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_d,
	output logic o_q
);
	import mwf_pkg::*;
	logic [SYNC_STAGES-1:0] st_r;
	logic [SYNC_STAGES-1:0] st_nxt;
	logic q_r;
	logic q_nxt;
	always_comb begin
		st_nxt = {st_r[SYNC_STAGES-2:0], i_d};
		q_nxt = q_r;
		// The first stage is seen only by the second, so metastability cannot spread.
		if (st_r[1] == st_r[2]) begin
			q_nxt = st_r[2];
		end
	end
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
			q_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			q_r <= q_nxt;
		end
	end
	assign o_q = q_r;
endmodule : mwf_sync
`default_nettype wire

// ==== test/mwf_fetch_monitor.sv ====
// Port checker of the fetch block.
// Assumes it is bound to mwf_fetch.
`timescale 1ns/1ns
`default_nettype none
module mwf_fetch_monitor
	import mwf_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [15:0] i_mem_word,
	input wire logic i_mem_valid,
	input wire logic i_skip,
	input wire logic [mwf_pkg::PC_W-1:0] o_mem_addr,
	input wire logic o_mem_req,
	input wire mwf_pkg::mwf_issue_t o_issue
);
	// ****************
	// Checks
	// ****************
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);
	logic iv;
	logic [20:0] tgt;
	logic [20:0] br;
	assign iv = o_issue.valid;
	assign tgt = {o_issue.lit1, o_issue.first[7:0], 1'b0};
	assign br = o_issue.pc + 21'h0_0002 + {{9{o_issue.first[10]}}, o_issue.first[10:0], 1'b0};
	// A redirect costs exactly one idle request cycle.
	sequence s_gap;
		!o_mem_req ##1 o_mem_req;
	endsequence
	a_addr_even: assert property (!o_mem_addr[0]) else $error("odd address");
	a_step_two: assert property ($changed(o_mem_addr)
		&& !(iv && o_issue.kind inside {K_JUMP, K_CALL, K_BRANCH})
		|-> o_mem_addr == $past(o_mem_addr) + 21'h0_0002) else $error("bad step");
	a_jump_tgt: assert property (iv && o_issue.kind == K_JUMP |-> o_mem_addr == tgt)
		else $error("bad jump target");
	a_call_tgt: assert property (iv && o_issue.kind == K_CALL |-> o_mem_addr == tgt)
		else $error("bad call target");
	a_branch_words: assert property (iv && o_issue.kind == K_BRANCH |-> o_mem_addr == br)
		else $error("bad branch target");
	a_class_jump: assert property (iv && o_issue.first[15:8] == OP_JUMP |->
		o_issue.kind == K_JUMP) else $error("jump misclassed");
	a_class_long: assert property (iv && o_issue.first[15:4] == OP_LONG_MOVE |->
		o_issue.kind == K_LONG_MOVE) else $error("long move misclassed");
	a_lone_nop: assert property (iv && o_issue.first[15:12] == EXT_PREFIX |->
		o_issue.kind == K_NOP_EXT) else $error("lone word not nop");
	a_redirect_gap: assert property (iv && o_issue.kind == K_JUMP |-> s_gap)
		else $error("no refetch gap");
endmodule : mwf_fetch_monitor
`default_nettype wire

// ==== test/mwf_prog_mem.sv ====
// Program memory model answering within the cycle of each request.
// Assumes the testbench fills the array while reset is held.
`timescale 1ns/1ns
`default_nettype none
module mwf_prog_mem (
	input wire logic [20:0] i_addr,
	input wire logic i_req,
	output logic [15:0] o_word,
	output logic o_valid
);
	// ****************
	// Storage
	// ****************
	logic [15:0] mem [256];
	initial begin
		foreach (mem[i]) mem[i] = 16'h0000;
	end
	// Idle cycles show the inverse so a stale word never looks fresh.
	assign o_valid = i_req;
	assign o_word = i_req ? mem[i_addr[8:1]] : ~mem[i_addr[8:1]];
endmodule : mwf_prog_mem
`default_nettype wire

// ==== test/tb_multiword_instruction_fetch.sv ====
// Testbench of the fetch block with a program memory model.
// Assumes the monitor is bound here and the skip input holds one level per scenario.
`timescale 1ns/1ns
`default_nettype none
module tb_multiword_instruction_fetch;
	import mwf_pkg::*;
	// ****************
	// Bench
	// ****************
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_skip = 1'b0;
	logic [15:0] mem_word;
	logic mem_valid;
	logic [20:0] mem_addr;
	logic mem_req;
	mwf_issue_t issue;
	mwf_issue_t got [$];
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [23:0] prog [21] = '{24'h00_C123, 24'h01_F456, 24'h02_0060, 24'h03_F48C,
		24'h04_F456, 24'h05_EE00, 24'h06_F123, 24'h07_0160, 24'h08_F001, 24'h09_F002,
		24'h0A_F777, 24'h0B_0F55, 24'h0C_EF40, 24'h0D_F000, 24'h0E_C111, 24'h40_D003,
		24'h41_C111, 24'h44_F000, 24'h45_EC45, 24'h46_F000, 24'h47_C111};
	logic [3:0] ek [10] = '{4'h3, 4'h5, 4'h4, 4'h6, 4'h8, 4'h0, 4'h1, 4'h7, 4'h8, 4'h2};
	logic [11:0] el [10] = '{12'h456, 12'h48C, 12'h123, 12'h001, 12'hFFF, 12'hFFF,
		12'h000, 12'hFFF, 12'hFFF, 12'h000};
	logic [7:0] ep [10] = '{8'h00, 8'h04, 8'h0A, 8'h0E, 8'h14, 8'h16, 8'h18, 8'h80, 8'h88, 8'h8A};
	logic [3:0] sk [6] = '{4'h3, 4'h5, 4'h4, 4'h6, 4'h1, 4'h2};
	logic [7:0] sp [6] = '{8'h00, 8'h04, 8'h0A, 8'h0E, 8'h18, 8'h8A};
	initial forever #20 i_sys_clk = ~i_sys_clk;
	mwf_fetch u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_mem_word(mem_word),
		.i_mem_valid(mem_valid), .i_skip(i_skip), .o_mem_addr(mem_addr),
		.o_mem_req(mem_req), .o_issue(issue));
	mwf_prog_mem u_mem (.i_addr(mem_addr), .i_req(mem_req),
		.o_word(mem_word), .o_valid(mem_valid));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic summarize;
		if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize
	// Reset with the program loaded; the skip level is set before release and kept.
	task automatic t_boot(input logic skip);
		#1 i_rst_n = 1'b0;
		i_skip = skip;
		got.delete();
		foreach (prog[i]) u_mem.mem[prog[i][23:16]] = prog[i][15:0];
		repeat (20) @(posedge i_sys_clk);
		check("reset address", mem_addr, 21'h0_0000);
		check("reset request", mem_req, 1'b0);
		#1 i_rst_n = 1'b1;
		repeat (60) @(posedge i_sys_clk);
	endtask : t_boot
	// A wrongly consumed word after each redirect would shift every later entry.
	task automatic t_program;
		t_boot(1'b0);
		check("issue count", got.size() > 9, 1'b1);
		for (int i = 0; i < 10; i++) begin
			check("kind", got[i].kind, ek[i]);
			check("pc", got[i].pc, {13'h0000, ep[i]});
			check("first", got[i].first, u_mem.mem[ep[i][7:1]]);
			if (el[i] !== 12'hFFF) check("literal one", got[i].lit1, el[i]);
		end
		check("literal two", got[1].lit2, 12'h456);
		check("literal two", got[3].lit2, 12'h002);
	endtask : t_program
	// Skip drops lone words and the branch; the move at the branch's fall-through
	// then meets a plain word and must be abandoned before the call retires.
	task automatic t_skip;
		t_boot(1'b1);
		check("skip issue count", got.size() > 5, 1'b1);
		for (int i = 0; i < 6; i++) begin
			check("skip kind", got[i].kind, sk[i]);
			check("skip pc", got[i].pc, {13'h0000, sp[i]});
		end
		check("skip call literal", got[5].lit1, 12'h000);
	endtask : t_skip
	// Sampled on the falling edge so registered outputs have settled.
	always @(negedge i_sys_clk) begin
		cycles++;
		if (issue.valid === 1'b1) got.push_back(issue);
		if (cycles == 1000) begin
			mismatches++;
			summarize();
		end
	end
	initial begin
		t_program();
		t_skip();
		t_program();
		summarize();
	end
endmodule : tb_multiword_instruction_fetch
bind mwf_fetch mwf_fetch_monitor u_mon (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
	.i_mem_word(i_mem_word), .i_mem_valid(i_mem_valid), .i_skip(i_skip),
	.o_mem_addr(o_mem_addr), .o_mem_req(o_mem_req), .o_issue(o_issue));
`default_nettype wire
